/* File: src/ihp_port.sv */
// Host bus port: ISA 16-bit and EISA 32-bit I/O slave with burst DMA data path.
// How it works
// RL1: ISA mode is a 16-bit I/O peripheral only; no 8-bit mode.
// RL2: Accesses are decoded only while address enable is low.
// RL3: Host gives address before read strobe; device answers read data.
// RL4: Address valid before write strobe; data captured on strobe trailing edge.
// RL5: Ready drops at strobe start if busy; rises on clock after ready.
// RL6: In 16-bit mode the two low byte enables pick the data lanes.
// RL7: Unselected lanes float on reads and are ignored on writes.
// RL8: Decode output is low when A15..A4 match and address enable is low.
// RL9: Board drives the 16-bit select from decode via open collector.
// RL10: EISA mode is a 32-bit asynchronous I/O slave, with optional burst DMA.
// RL11: Glue forms read and write strobes from latched direction and command.
// RL12: EISA I/O accesses never need the ready line pulled low.
// RL13: DMA bursts move up to one doubleword per bus clock.
// RL14: DMA is doubleword aligned; CPU moves unaligned end bytes by I/O.
// RL15: During bursts, bus ready is sampled and held-off cycles are skipped.
// RL16: EISA mode latches A2..A15 on address strobe trailing edge.
// RL17: Address enable passes while address strobe is low, held from its rise.
// RL18: Host keeps read and write strobes inactive during DMA bursts.
// RL19: Data path select, from DMA acknowledge, opens the data path.
// RL20: Direction input high means device written, low means device read.
// RL21: Bus clock on the local clock input paces DMA transfers.
// RL22: The four interrupt outputs are active-high edge requests.
`timescale 1ns/10ps
`default_nettype none
module ihp_port
  import ihp_pkg::*;
#(
  parameter int          DEPTH = FIFO_DEPTH,
  parameter logic [11:0] BASE  = IO_BASE_RST
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic        EISA_MODE,
  input  wire logic [15:1] ADDR,
  input  wire logic        ADDR_ENABLE,
  input  wire logic        IO_READ_STROBE_N,
  input  wire logic        IO_WRITE_STROBE_N,
  input  wire logic        BYTE_ENABLE_0_N,
  input  wire logic        BYTE_ENABLE_1_N,
  input  wire logic        BYTE_ENABLE_2_N,
  input  wire logic        BYTE_ENABLE_3_N,
  input  wire logic        ADDRESS_STROBE_N,
  input  wire logic        DATA_PATH_SELECT_N,
  input  wire logic        TRANSFER_DIRECTION,
  input  wire logic        LOCAL_BUS_CLOCK,
  input  wire logic        BUS_READY,
  input  wire logic [31:0] DATA_IN,
  output logic      [31:0] DATA_OUT,
  output logic      [3:0]  DATA_OE,
  output logic             ASYNC_READY_OUT,
  output logic             LOCAL_DEVICE_DECODE_N,
  input  wire logic [3:0]  INTERRUPT_SRC,
  output logic      [3:0]  INTERRUPT_OUTPUTS,
  output logic      [31:0] WR_DATA,
  output logic      [3:0]  WR_LANES,
  output logic      [15:2] WR_ADDR,
  output logic             WR_VALID,
  input  wire logic        WR_READY,
  output logic      [15:1] RD_ADDR,
  output logic             RD_REQ,
  input  wire logic [31:0] RD_DATA,
  input  wire logic        RD_VALID,
  input  wire logic [31:0] DMA_TX_DATA,
  input  wire logic        DMA_TX_VALID,
  output logic             DMA_TX_READY
);
  // Two-flop synchronisers for the host strobes, control pins and data; address and byte enables are used unsynchronised.
  localparam int NS = 10;
  // Idle level of every synchronised pin, so that no false edge follows reset.
  localparam logic [NS-1:0] SYNC_IDLE = 10'h3cf;
  logic [NS-1:0] s1_r, s2_r, s3_r;
  logic [31:0]   din_s1_r, din_s2_r;
  logic          rd_n, wr_n, ads_n, dcs_n, dir, local_bus_clock, exrdy, aen_p;
  logic          local_bus_clock_d_r, ads_d_r, wr_d_r;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s1_r     <= SYNC_IDLE;
      s2_r     <= SYNC_IDLE;
      din_s1_r <= '0;
      din_s2_r <= '0;
      local_bus_clock_d_r <= 1'b0;
      ads_d_r  <= 1'b1;
      wr_d_r   <= 1'b1;
    end else begin
      s1_r     <= {IO_READ_STROBE_N, IO_WRITE_STROBE_N, ADDRESS_STROBE_N, DATA_PATH_SELECT_N,
                   TRANSFER_DIRECTION, LOCAL_BUS_CLOCK, BUS_READY, ADDR_ENABLE, 2'b11};
      s2_r     <= s1_r;
      din_s1_r <= DATA_IN;
      din_s2_r <= din_s1_r;
      local_bus_clock_d_r <= local_bus_clock;
      ads_d_r  <= ads_n;
      wr_d_r   <= wr_n;
    end
  end
  assign s3_r  = s2_r;
  assign rd_n  = s3_r[9];
  assign wr_n  = s3_r[8];
  assign ads_n = s3_r[7];
  assign dcs_n = s3_r[6];
  assign dir   = s3_r[5];
  assign local_bus_clock  = s3_r[4];
  assign exrdy = s3_r[3];
  assign aen_p = s3_r[2];

  // Address enable and EISA address latch, held from the address strobe rise.
  logic        aen_hold_r, aen_hold_nxt, aen_eff;
  logic [15:2] alat_r, alat_nxt;
  logic [3:0]  be_lat_r, be_lat_nxt;
  logic        ads_rise;
  assign ads_rise = ads_n && !ads_d_r;

  always_comb begin
    aen_hold_nxt = aen_hold_r;
    alat_nxt     = alat_r;
    be_lat_nxt   = be_lat_r;
    if (!ads_n) begin
      aen_hold_nxt = aen_p; // RL17
    end
    if (ads_rise) begin
      alat_nxt   = ADDR[15:2]; // RL16
      be_lat_nxt = {BYTE_ENABLE_3_N, BYTE_ENABLE_2_N, BYTE_ENABLE_1_N, BYTE_ENABLE_0_N};
    end
  end
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      aen_hold_r <= 1'b1;
      alat_r     <= '0;
      be_lat_r   <= '1;
    end else begin
      aen_hold_r <= aen_hold_nxt;
      alat_r     <= alat_nxt;
      be_lat_r   <= be_lat_nxt;
    end
  end
  // Glue ORs M/IO into address enable; ISA passes it straight through.
  assign aen_eff = EISA_MODE ? (ads_n ? aen_hold_r : aen_p) : aen_p; // RL17

  // In ISA mode the decode is combinational from the address pins; EISA mode decodes the latched address alat_r.
  logic [15:4] dec_addr;
  logic        hit;
  assign dec_addr = EISA_MODE ? alat_r[15:4] : ADDR[15:4];
  assign hit      = (dec_addr == BASE) && !aen_eff; // RL2 RL8
  assign LOCAL_DEVICE_DECODE_N = !hit; // RL8

  // Lane selection: ISA uses two enables only; EISA uses all four.
  logic [3:0] lanes;
  always_comb begin
    if (EISA_MODE) begin
      lanes = ~be_lat_r; // RL10
    end else begin
      lanes = {2'b00, !BYTE_ENABLE_1_N, !BYTE_ENABLE_0_N}; // RL1 RL6
    end
  end

  // I/O access state machine.
  ihp_state_t  st_r, st_nxt;
  logic [31:0] dout_r, dout_nxt;
  logic [3:0]  oe_r, oe_nxt;
  logic        rdy_r, rdy_nxt;
  logic        wv_r, wv_nxt;
  logic [31:0] wd_r, wd_nxt;
  logic [3:0]  wl_r, wl_nxt;
  logic [15:2] wa_r, wa_nxt;
  logic [31:0] wcap_r, wcap_nxt;
  logic        rreq_r, rreq_nxt;
  logic        dma_on;
  logic        local_bus_clock_rise;
  logic        dma_wr_push, dma_take;
  logic [31:0] f_odata;
  logic        f_ovalid, f_iready;

  assign dma_on    = !dcs_n && EISA_MODE;
  assign local_bus_clock_rise = local_bus_clock && !local_bus_clock_d_r; // RL21

  always_comb begin
    st_nxt   = st_r;
    dout_nxt = dout_r;
    oe_nxt   = oe_r;
    rdy_nxt  = rdy_r;
    wd_nxt   = wd_r;
    wl_nxt   = wl_r;
    wa_nxt   = wa_r;
    wcap_nxt = wcap_r;
    wv_nxt   = wv_r && !WR_READY;
    rreq_nxt = 1'b0;
    case (st_r)
      IHP_IDLE: begin
        oe_nxt = 4'h0;
        if (hit && !rd_n && !dma_on) begin
          st_nxt   = IHP_RWAIT;
          rreq_nxt = 1'b1; // RL3
          rdy_nxt  = EISA_MODE; // RL5 RL12
        end else if (hit && !wr_n && !dma_on) begin
          st_nxt  = IHP_WACT;
          rdy_nxt = EISA_MODE || !wv_r; // RL5 RL12
        end
      end
      IHP_RWAIT: begin
        if (RD_VALID) begin
          dout_nxt = RD_DATA;
          oe_nxt   = lanes; // RL7
          rdy_nxt  = 1'b1; // RL5
          st_nxt   = IHP_RDATA;
        end
      end
      IHP_RDATA: begin
        if (rd_n) begin
          oe_nxt = 4'h0;
          st_nxt = IHP_IDLE;
        end
      end
      IHP_WACT: begin
        if (!wv_r) begin
          rdy_nxt = 1'b1; // RL5
        end
        // Data rides the same two flops as the strobe, so the last word kept is
        // the one on the pins at the trailing edge, whatever the host does later.
        if (!wr_n) begin
          wcap_nxt = din_s2_r; // RL4
        end
        if (wr_n && !wr_d_r) begin
          st_nxt = IHP_WDONE;
        end else if (wr_n) begin
          st_nxt = IHP_WDONE;
        end
      end
      IHP_WDONE: begin
        if (!wv_r || WR_READY) begin
          wd_nxt = wcap_r; // RL4
          wl_nxt = lanes; // RL7
          wa_nxt = EISA_MODE ? alat_r : ADDR[15:2];
          wv_nxt = 1'b1;
          st_nxt = IHP_IDLE;
        end
      end
      default: st_nxt = IHP_IDLE;
    endcase
    if (dma_on && !dir && f_ovalid) begin
      dout_nxt = f_odata; // RL20
      oe_nxt   = 4'hf;
    end else if (dma_on && dir) begin
      oe_nxt = 4'h0;
    end
    if (dma_wr_push && (!wv_r || WR_READY)) begin
      wd_nxt = din_s2_r; // RL20
      wl_nxt = 4'hf;
      wa_nxt = alat_r;
      wv_nxt = 1'b1; // RL13
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      st_r   <= IHP_IDLE;
      dout_r <= '0;
      oe_r   <= '0;
      rdy_r  <= 1'b1;
      wd_r   <= '0;
      wl_r   <= '0;
      wa_r   <= '0;
      wcap_r <= '0;
      wv_r   <= 1'b0;
      rreq_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      dout_r <= dout_nxt;
      oe_r   <= oe_nxt;
      rdy_r  <= rdy_nxt;
      wd_r   <= wd_nxt;
      wl_r   <= wl_nxt;
      wa_r   <= wa_nxt;
      wcap_r <= wcap_nxt;
      wv_r   <= wv_nxt;
      rreq_r <= rreq_nxt;
    end
  end

  // DMA read path buffers outgoing doublewords; one moves per rising bus clock edge while bus ready is high.
  assign dma_take    = dma_on && !dir && local_bus_clock_rise && exrdy; // RL13 RL15 RL19
  assign dma_wr_push = dma_on && dir && local_bus_clock_rise && exrdy; // RL15 RL20

  ihp_fifo #(.W(DATA_W), .D(DEPTH)) u_fifo (
    .clk       (CLK_SYS),
    .rst       (RST),
    .in_data   (DMA_TX_DATA),
    .in_valid  (DMA_TX_VALID),
    .in_ready  (f_iready),
    .out_data  (f_odata),
    .out_valid (f_ovalid),
    .out_ready (dma_take)
  );
  assign DMA_TX_READY = f_iready;

  // Interrupt requests are registered active-high levels whose edges signal events.
  logic [3:0] irq_r;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      irq_r <= '0;
    end else begin
      irq_r <= INTERRUPT_SRC; // RL22
    end
  end

  // A DMA write doubleword goes out on the write port only if the port is free at that bus clock edge; otherwise it is lost.
  assign WR_DATA   = wd_r;
  assign WR_LANES  = wl_r;
  assign WR_ADDR   = wa_r;
  assign WR_VALID  = wv_r;
  assign RD_ADDR   = EISA_MODE ? {alat_r, 1'b0} : ADDR[15:1];
  assign RD_REQ    = rreq_r;
  assign DATA_OUT  = dout_r;
  assign DATA_OE   = oe_r;
  assign ASYNC_READY_OUT   = rdy_r;
  assign INTERRUPT_OUTPUTS = irq_r;

  ready_after_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st_r == IHP_RWAIT && RD_VALID) |=> ASYNC_READY_OUT) else $error("ready not raised"); // RL5
  decode_blocked_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    aen_eff |-> LOCAL_DEVICE_DECODE_N) else $error("decode while enable high"); // RL2
  isa_lanes_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (!EISA_MODE && st_r == IHP_RDATA) |-> (DATA_OE[3:2] == 2'b00)) else $error("upper lanes"); // RL1
  eisa_ready_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL12
    (EISA_MODE && st_r != IHP_RWAIT && !dma_on) |-> ##1 (EISA_MODE -> ASYNC_READY_OUT))
    else $error("eisa ready low");
  write_capture_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL4
    (st_r == IHP_WDONE && !wv_r) |=> (WR_VALID && WR_DATA == $past(wcap_r)))
    else $error("write data not captured");
  dma_pop_a: assert property (@(posedge CLK_SYS) disable iff (RST) // RL15
    (dma_on && !dir && local_bus_clock_rise && !exrdy && f_ovalid) |=> $stable(f_odata))
    else $error("pop during wait");
  irq_follow_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    ##1 (INTERRUPT_OUTPUTS == $past(INTERRUPT_SRC))) else $error("irq mismatch"); // RL22
  read_req_a: assert property (@(posedge CLK_SYS) disable iff (RST)
    (st_r == IHP_IDLE && hit && !rd_n && !dma_on) |=> RD_REQ) else $error("no read request"); // RL3
endmodule
`default_nettype wire

/* File: src/ihp_pkg.sv */
// Package with constants and types for the ISA/EISA host bus port.
package ihp_pkg;
  localparam int          CLK_HZ          = 20000000;
  localparam int          EISA_MIN_ACC_NS = 180;
  localparam int          EISA_MIN_ACC_CY = (EISA_MIN_ACC_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [11:0] IO_BASE_RST     = 12'h030;
  localparam int          ADDR_HI         = 15;
  localparam int          ADDR_LO_DEC     = 4;
  localparam int          FIFO_DEPTH      = 16;
  localparam int          DATA_W          = 32;
  localparam logic [1:0]  RDY_DELAY_CY    = 2'h2;
  typedef enum logic [2:0] {
    IHP_IDLE  = 3'b000,
    IHP_RWAIT = 3'b001,
    IHP_RDATA = 3'b010,
    IHP_WACT  = 3'b011,
    IHP_WDONE = 3'b100
  } ihp_state_t;
endpackage

/* File: src/ihp_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module ihp_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0]   cnt_r, cnt_nxt;
  logic          push, pop;

  assign in_ready  = (cnt_r != (AW+1)'(D));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rp_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    wp_nxt  = push ? wp_r + 1'b1 : wp_r;
    rp_nxt  = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
    if (push) begin
      mem[wp_r] <= in_data;
    end
  end
endmodule
`default_nettype wire

/* File: tb/ihp_host_model.sv */
// Model of the host bus and its glue logic, driving the port's pins.
`timescale 1ns/10ps
`default_nettype none
module ihp_host_model (
  input  wire logic        CLK_SYS,
  input  wire logic [31:0] DATA_OUT,
  input  wire logic [3:0]  DATA_OE,
  input  wire logic        ASYNC_READY_OUT,
  output logic      [15:1] ADDR,
  output logic             ADDR_ENABLE,
  output logic             IO_READ_STROBE_N,
  output logic             IO_WRITE_STROBE_N,
  output logic             BYTE_ENABLE_0_N,
  output logic             BYTE_ENABLE_1_N,
  output logic             BYTE_ENABLE_2_N,
  output logic             BYTE_ENABLE_3_N,
  output logic             ADDRESS_STROBE_N,
  output logic             DATA_PATH_SELECT_N,
  output logic             TRANSFER_DIRECTION,
  output logic             LOCAL_BUS_CLOCK,
  output logic             BUS_READY,
  output logic      [31:0] DATA_IN
);
  initial begin
    drive(16'h0, 4'hf, 1'b1);
    {IO_READ_STROBE_N, IO_WRITE_STROBE_N, DATA_PATH_SELECT_N} = 3'h7;
    // An ISA slot ties the address strobe low, so the address enable hold stays open.
    {LOCAL_BUS_CLOCK, ADDRESS_STROBE_N, TRANSFER_DIRECTION, BUS_READY} = 4'h3;
    DATA_IN = 32'h0;
  end

  task automatic drive(input logic [15:0] a, input logic [3:0] be, input logic aen);
    ADDR = a[15:1];
    {BYTE_ENABLE_3_N, BYTE_ENABLE_2_N, BYTE_ENABLE_1_N, BYTE_ENABLE_0_N} = be;
    ADDR_ENABLE = aen;
  endtask

  task automatic io(input logic wr, input logic [31:0] d, output logic [31:0] q,
                    output logic [3:0] oe, output logic lo);
    int n;
    n = 0;
    lo = 0;
    DATA_IN = d;
    repeat (2) @(negedge CLK_SYS);
    if (wr) IO_WRITE_STROBE_N = 0;
    else IO_READ_STROBE_N = 0;
    // Strobes last at least eight cycles, longer than the shortest slot command.
    while (n < 40 && !(n >= 8 && ASYNC_READY_OUT === 1'b1)) begin
      @(negedge CLK_SYS);
      lo |= (ASYNC_READY_OUT !== 1'b1);
      n++;
    end
    // A strobe that never sees ready again counts against the run.
    if (n >= 40) begin
      tb_top.num_errors++;
    end
    q = DATA_OUT;
    oe = DATA_OE;
    {IO_READ_STROBE_N, IO_WRITE_STROBE_N} = 2'h3;
    repeat (2) @(negedge CLK_SYS);
    DATA_IN = ~d;
  endtask

  task automatic eisa_start(input logic [15:0] a);
    ADDRESS_STROBE_N = 1;
    drive(a, 4'h0, 1'b0);
    @(negedge CLK_SYS);
    ADDRESS_STROBE_N = 0;
    repeat (3) @(negedge CLK_SYS);
    ADDRESS_STROBE_N = 1;
    repeat (3) @(negedge CLK_SYS);
    // Pins go stale after the start phase; only the latched copy may count.
    drive(~a, 4'hf, 1'b1);
  endtask

  task automatic burst(input int n, input logic [7:0] pat, input logic dir);
    DATA_PATH_SELECT_N = 0;
    TRANSFER_DIRECTION = dir;
    repeat (3) @(negedge CLK_SYS);
    // The bus clock has no phase tie to the system clock.
    #13;
    for (int i = 0; i < n; i++) begin
      BUS_READY = pat[i % 8];
      #100 LOCAL_BUS_CLOCK = 1;
      #200 LOCAL_BUS_CLOCK = 0;
      #100;
    end
    BUS_READY = 1;
    repeat (4) @(negedge CLK_SYS);
    DATA_PATH_SELECT_N = 1;
  endtask
endmodule
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the host bus port.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ihp_pkg::*;
  logic        CLK_SYS, RST, EISA_MODE, ADDR_ENABLE, IO_READ_STROBE_N, IO_WRITE_STROBE_N;
  logic        BYTE_ENABLE_0_N, BYTE_ENABLE_1_N, BYTE_ENABLE_2_N, BYTE_ENABLE_3_N;
  logic        ADDRESS_STROBE_N, DATA_PATH_SELECT_N, TRANSFER_DIRECTION, LOCAL_BUS_CLOCK;
  logic        BUS_READY, ASYNC_READY_OUT, LOCAL_DEVICE_DECODE_N, WR_VALID, WR_READY;
  logic        RD_REQ, RD_VALID, DMA_TX_VALID, DMA_TX_READY;
  logic [31:0] DATA_IN, DATA_OUT, WR_DATA, RD_DATA, DMA_TX_DATA, wd;
  logic [15:1] ADDR, RD_ADDR;
  logic [15:2] WR_ADDR, wa;
  logic [3:0]  DATA_OE, INTERRUPT_SRC, INTERRUPT_OUTPUTS, WR_LANES, wl;
  int          num_errors = 0, checked = 0, wcnt = 0, rcnt = 0;
  logic        io_cs16_n;

  // The board's open-collector buffer lets the select float to its pull-up.
  assign io_cs16_n = (LOCAL_DEVICE_DECODE_N === 1'b0) ? 1'b0 : 1'b1;

  ihp_port i_ihp_port (.*);
  ihp_host_model i_ihp_host_model (.*);

  initial begin
    CLK_SYS = 0;
    forever #25 CLK_SYS = ~CLK_SYS;
  end

  always @(posedge CLK_SYS) begin
    if (WR_VALID === 1'b1 && WR_READY === 1'b1) begin
      wcnt <= wcnt + 1;
      wd   <= WR_DATA;
      wl   <= WR_LANES;
      wa   <= WR_ADDR;
    end
  end

  initial begin
    RD_VALID = 0;
    RD_DATA = 32'h0;
    forever begin
      @(negedge CLK_SYS);
      RD_VALID = (RD_REQ === 1'b1);
      RD_DATA = RD_VALID ? {16'h5a3c, RD_ADDR, 1'b0} : ~RD_DATA;
      rcnt += int'(RD_VALID);
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out;
    if (num_errors == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic t_reset;
    chk("ready", 32'(ASYNC_READY_OUT), 32'h1);
    chk("lanes", 32'(DATA_OE), 32'h0);
  endtask

  task automatic t_decode;
    logic [16:0] c [3] = '{17'h00300, 17'h00400, 17'h10300};
    logic [31:0] q;
    logic [3:0]  oe;
    logic        lo;
    int          r;
    for (int i = 0; i < 3; i++) begin
      i_ihp_host_model.drive(c[i][15:0], 4'hc, c[i][16]);
      repeat (3) @(negedge CLK_SYS);
      chk("decode", 32'(LOCAL_DEVICE_DECODE_N), 32'(i != 0));
      chk("cs16", 32'(io_cs16_n), 32'(i != 0));
    end
    r = rcnt;
    i_ihp_host_model.io(1'b0, 32'h0, q, oe, lo);
    chk("blocked req", 32'(rcnt - r), 32'h0);
    chk("blocked lanes", 32'(oe), 32'h0);
  endtask

  task automatic t_isa;
    logic [1:0]  b;
    logic [15:0] a;
    logic [31:0] d, m, q;
    logic [3:0]  oe;
    logic        lo;
    int          n;
    for (int k = 0; k < 6; k++) begin
      b = 2'((k * 2) % 3);
      a = 16'h0300 + 16'((k % 3) * 4);
      d = 32'h0000_c300 + 32'(k);
      m = {16'h0, {8{~b[1]}}, {8{~b[0]}}};
      n = wcnt;
      i_ihp_host_model.drive(a, {2'b11, b}, 1'b0);
      i_ihp_host_model.io(k > 2, d, q, oe, lo);
      repeat (4) @(negedge CLK_SYS);
      if (k < 3) begin
        chk("rd lanes", 32'(oe), {30'h0, ~b});
        chk("rd data", q & m, {16'h5a3c, a} & m);
        chk("rd wait", 32'(lo), 32'h1);
        chk("rd float", 32'(DATA_OE), 32'h0);
      end else begin
        chk("wr count", 32'(wcnt - n), 32'h1);
        chk("wr lanes", 32'(wl), {30'h0, ~b});
        chk("wr data", wd & m, d & m);
        chk("wr addr", 32'(wa), 32'(a[15:2]));
      end
    end
  endtask

  task automatic t_eisa;
    logic [31:0] q;
    logic [3:0]  oe;
    logic        lo;
    EISA_MODE = 1;
    i_ihp_host_model.eisa_start(16'h030c);
    i_ihp_host_model.io(1'b1, 32'h1234_abcd, q, oe, lo);
    repeat (4) @(negedge CLK_SYS);
    chk("e wr lanes", 32'(wl), 32'hf);
    chk("e wr data", wd, 32'h1234_abcd);
    chk("e wr addr", 32'(wa), 32'h00c3);
    chk("e wr ready", 32'(lo), 32'h0);
    i_ihp_host_model.eisa_start(16'h0308);
    i_ihp_host_model.io(1'b0, 32'h0, q, oe, lo);
    chk("e rd lanes", 32'(oe), 32'hf);
    chk("e rd data", q, 32'h5a3c_0308);
    chk("e rd ready", 32'(lo), 32'h0);
  endtask

  task automatic push(output int n);
    n = 0;
    repeat (20) begin
      @(negedge CLK_SYS);
      if (DMA_TX_READY !== 1'b1) begin
        DMA_TX_VALID = 0;
        break;
      end
      DMA_TX_DATA = 32'(n);
      DMA_TX_VALID = 1;
      n++;
    end
    @(negedge CLK_SYS);
    DMA_TX_VALID = 0;
  endtask

  task automatic t_dma;
    int n;
    int w;
    push(n);
    chk("fill", 32'(n), 32'(FIFO_DEPTH));
    w = wcnt;
    i_ihp_host_model.burst(4, 8'hff, 1'b1);
    chk("dma wr count", 32'(wcnt - w), 32'h4);
    chk("dma wr addr", 32'(wa), 32'h00c2);
    push(n);
    chk("wr burst", 32'(n), 32'h0);
    i_ihp_host_model.burst(6, 8'b0010_1101, 1'b0);
    push(n);
    chk("held off", 32'(n), 32'h4);
    i_ihp_host_model.burst(20, 8'hff, 1'b0);
    push(n);
    chk("drain", 32'(n), 32'(FIFO_DEPTH));
  endtask

  task automatic t_irq;
    for (int i = 0; i < 2; i++) begin
      INTERRUPT_SRC = i ? 4'ha : 4'h5;
      repeat (4) @(negedge CLK_SYS);
      chk("irq", 32'(INTERRUPT_OUTPUTS), i ? 32'ha : 32'h5);
    end
  endtask

  initial begin
    repeat (5000) @(negedge CLK_SYS);
    num_errors++;
    close_out;
  end

  initial begin
    {RST, EISA_MODE, WR_READY, DMA_TX_VALID} = 4'ha;
    {DMA_TX_DATA, INTERRUPT_SRC} = '0;
    repeat (20) @(negedge CLK_SYS);
    RST = 0;
    repeat (4) @(negedge CLK_SYS);
    t_reset;
    t_decode;
    t_isa;
    t_irq;
    t_eisa;
    t_dma;
    close_out;
  end
endmodule
`default_nettype wire
